// ---- src/jtid_tap.v ----
`timescale 1ns/1ps
`include "jtid_regs.vh"
module jtid_tap #(
  parameter LONG_VARIANT = 1,
  parameter [31:0] ID_VALUE = 32'h00001001 // Arbitrary identity value
) (
  clk,
  arst_n,
  clk_en,
  tck,
  tms,
  tdi,
  tdo_o,
  tdo_oe,
  bsr_capture_in,
  bsr_update_out,
  bsr_extest,
  flash_control_scan_reg,
  flash_data_scan_reg,
  flash_address_scan_reg,
  flash_scale_scan_reg,
  flash_update_sel,
  flash_update_stb
);
  localparam BW = LONG_VARIANT ? `JTID_BSR_LONG : `JTID_BSR_SHORT;
  input wire clk;
  input wire arst_n;
  input wire clk_en;
  input wire tck;
  input wire tms;
  input wire tdi;
  output reg tdo_o;
  output reg tdo_oe;
  input wire [BW-1:0] bsr_capture_in;
  output reg [BW-1:0] bsr_update_out;
  output reg bsr_extest;
  output reg [`JTID_FCTL_W-1:0] flash_control_scan_reg;
  output reg [`JTID_FDAT_W-1:0] flash_data_scan_reg;
  output reg [`JTID_FADR_W-1:0] flash_address_scan_reg;
  output reg [`JTID_FSCL_W-1:0] flash_scale_scan_reg;
  output reg [1:0] flash_update_sel;
  output reg flash_update_stb;

  // **********
  // TAP states
  // **********
  localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SELDR = 4'h2, S_CAPDR = 4'h3,
    S_SHDR = 4'h4, S_EX1DR = 4'h5, S_PAUDR = 4'h6, S_EX2DR = 4'h7, S_UPDR = 4'h8,
    S_SELIR = 4'h9, S_CAPIR = 4'ha, S_SHIR = 4'hb, S_EX1IR = 4'hc, S_PAUIR = 4'hd,
    S_EX2IR = 4'he, S_UPIR = 4'hf;
  localparam [2:0] D_BSR = 3'h0, D_BYP = 3'h1, D_ID = 3'h2, D_FCTL = 3'h3,
    D_FDAT = 3'h4, D_FADR = 3'h5, D_FSCL = 3'h6;

  // ***************************
  // Pin synchronisers and edges
  // ***************************
  // Pins come from the tester's domain; tck is sampled, not used as a clock
  reg [2:0] tck_q;
  reg [1:0] tms_q;
  reg [1:0] tdi_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_q <= 3'h0;
      tms_q <= 2'h0;
      tdi_q <= 2'h0;
    end else if (clk_en) begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
    end
  end
  wire tck_rise = clk_en & tck_q[1] & ~tck_q[2];
  wire tck_fall = clk_en & ~tck_q[1] & tck_q[2];

  // ***********
  // Controller
  // ***********
  reg [3:0] st_q;
  reg [3:0] st_d;
  always @* begin
    case (st_q)
      S_RESET: st_d = tms_q[1] ? S_RESET : S_IDLE;
      S_IDLE: st_d = tms_q[1] ? S_SELDR : S_IDLE;
      S_SELDR: st_d = tms_q[1] ? S_SELIR : S_CAPDR;
      S_CAPDR: st_d = tms_q[1] ? S_EX1DR : S_SHDR;
      S_SHDR: st_d = tms_q[1] ? S_EX1DR : S_SHDR;
      S_EX1DR: st_d = tms_q[1] ? S_UPDR : S_PAUDR;
      S_PAUDR: st_d = tms_q[1] ? S_EX2DR : S_PAUDR;
      S_EX2DR: st_d = tms_q[1] ? S_UPDR : S_SHDR;
      S_UPDR: st_d = tms_q[1] ? S_SELDR : S_IDLE;
      S_SELIR: st_d = tms_q[1] ? S_RESET : S_CAPIR;
      S_CAPIR: st_d = tms_q[1] ? S_EX1IR : S_SHIR;
      S_SHIR: st_d = tms_q[1] ? S_EX1IR : S_SHIR;
      S_EX1IR: st_d = tms_q[1] ? S_UPIR : S_PAUIR;
      S_PAUIR: st_d = tms_q[1] ? S_EX2IR : S_PAUIR;
      S_EX2IR: st_d = tms_q[1] ? S_UPIR : S_SHIR;
      S_UPIR: st_d = tms_q[1] ? S_SELDR : S_IDLE;
      default: st_d = S_RESET;
    endcase
  end

  // ******************
  // Instruction decode
  // ******************
  reg [`JTID_IR_W-1:0] ir_q;
  reg [`JTID_IR_W-1:0] irsh_q;
  reg [2:0] sel;
  always @* begin
    case (ir_q)
      `JTID_OP_EXTEST: sel = D_BSR;
      `JTID_OP_SAMPLE: sel = D_BSR;
      `JTID_OP_IDCODE: sel = D_ID;
      `JTID_OP_FCTL: sel = D_FCTL;
      `JTID_OP_FDAT: sel = D_FDAT;
      `JTID_OP_FADR: sel = D_FADR;
      `JTID_OP_FSCL: sel = D_FSCL;
      default: sel = D_BYP; // Unknown codes act as bypass
    endcase
  end

  // *********************
  // Data register shifts
  // *********************
  reg [BW-1:0] bsr_q;
  reg byp_q;
  reg [31:0] id_q;
  reg [`JTID_FCTL_W-1:0] fctl_q;
  reg [`JTID_FDAT_W-1:0] fdat_q;
  reg [`JTID_FADR_W-1:0] fadr_q;
  reg [`JTID_FSCL_W-1:0] fscl_q;
  reg dr_out;
  always @* begin
    case (sel)
      D_BSR: dr_out = bsr_q[0];
      D_ID: dr_out = id_q[0];
      D_FCTL: dr_out = fctl_q[0];
      D_FDAT: dr_out = fdat_q[0];
      D_FADR: dr_out = fadr_q[0];
      D_FSCL: dr_out = fscl_q[0];
      default: dr_out = byp_q;
    endcase
  end
  wire d = tdi_q[1];
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_RESET;
      ir_q <= `JTID_IR_RST;
      irsh_q <= `JTID_IR_RST;
      bsr_q <= {BW{1'b0}};
      byp_q <= 1'b0;
      id_q <= 32'h0;
      fctl_q <= {`JTID_FCTL_W{1'b0}};
      fdat_q <= {`JTID_FDAT_W{1'b0}};
      fadr_q <= {`JTID_FADR_W{1'b0}};
      fscl_q <= {`JTID_FSCL_W{1'b0}};
      flash_control_scan_reg <= {`JTID_FCTL_W{1'b0}};
      flash_data_scan_reg <= {`JTID_FDAT_W{1'b0}};
      flash_address_scan_reg <= {`JTID_FADR_W{1'b0}};
      flash_scale_scan_reg <= {`JTID_FSCL_W{1'b0}};
      bsr_update_out <= {BW{1'b0}};
      bsr_extest <= 1'b0;
      flash_update_sel <= 2'h0;
      flash_update_stb <= 1'b0;
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (clk_en) begin
      flash_update_stb <= 1'b0;
      // Extest only drives pins once it is the active instruction
      bsr_extest <= (ir_q == `JTID_OP_EXTEST);
      if (tck_fall) begin
        // Data out changes on falling tck, driven only while shifting
        tdo_oe <= (st_q == S_SHDR) || (st_q == S_SHIR);
        tdo_o <= (st_q == S_SHIR) ? irsh_q[0] : dr_out;
      end
      if (tck_rise) begin
        st_q <= st_d;
        case (st_q)
          S_RESET: ir_q <= `JTID_IR_RST;
          S_CAPIR: irsh_q <= `JTID_IR_CAPT;
          S_SHIR: irsh_q <= {d, irsh_q[`JTID_IR_W-1:1]};
          S_UPIR: ir_q <= irsh_q;
          S_CAPDR: begin
            case (sel)
              D_BSR: bsr_q <= bsr_capture_in;
              D_ID: id_q <= ID_VALUE;
              D_FCTL: fctl_q <= flash_control_scan_reg;
              D_FDAT: fdat_q <= flash_data_scan_reg;
              D_FADR: fadr_q <= flash_address_scan_reg;
              D_FSCL: fscl_q <= flash_scale_scan_reg;
              default: byp_q <= 1'b0;
            endcase
          end
          S_SHDR: begin
            case (sel)
              D_BSR: bsr_q <= {d, bsr_q[BW-1:1]};
              D_ID: id_q <= {d, id_q[31:1]};
              D_FCTL: fctl_q <= {d, fctl_q[`JTID_FCTL_W-1:1]};
              D_FDAT: fdat_q <= {d, fdat_q[`JTID_FDAT_W-1:1]};
              D_FADR: fadr_q <= {d, fadr_q[`JTID_FADR_W-1:1]};
              D_FSCL: fscl_q <= {d, fscl_q[`JTID_FSCL_W-1:1]};
              default: byp_q <= d;
            endcase
          end
          S_UPDR: begin
            case (sel)
              D_BSR: if (ir_q == `JTID_OP_EXTEST) bsr_update_out <= bsr_q;
              D_FCTL: begin
                flash_control_scan_reg <= fctl_q;
                flash_update_sel <= 2'h0;
                flash_update_stb <= 1'b1;
              end
              D_FDAT: begin
                flash_data_scan_reg <= fdat_q;
                flash_update_sel <= 2'h1;
                flash_update_stb <= 1'b1;
              end
              D_FADR: begin
                flash_address_scan_reg <= fadr_q;
                flash_update_sel <= 2'h2;
                flash_update_stb <= 1'b1;
              end
              D_FSCL: begin
                flash_scale_scan_reg <= fscl_q;
                flash_update_sel <= 2'h3;
                flash_update_stb <= 1'b1;
              end
              default: byp_q <= byp_q;
            endcase
          end
          default: st_q <= st_d;
        endcase
      end
    end
  end
endmodule // jtid_tap

// ---- src/jtid_regs.vh ----
// Functional notes
// - Standard tap state machine governs all scans
// - Only test clock, mode, data in/out pins
// - Instruction register is sixteen bits wide
// - Eight instruction codes each pick one register
// - Boundary, bypass, ident plus four flash registers
// - Code 0x0084 selects flash address register
// - Capture, shift, update phases for every access
// - External test updates pins; sample only captures
// - Boundary register 126 or 118 bits long
`ifndef JTID_REGS_VH
`define JTID_REGS_VH
`define JTID_IR_W 16
`define JTID_IR_RST 16'h0000
`define JTID_IR_CAPT 16'h0001
`define JTID_OP_EXTEST 16'h0000
`define JTID_OP_SAMPLE 16'h0002
`define JTID_OP_IDCODE 16'h0004
`define JTID_OP_BYPASS 16'hffff
`define JTID_OP_FCTL 16'h0082
`define JTID_OP_FDAT 16'h0083
`define JTID_OP_FADR 16'h0084
`define JTID_OP_FSCL 16'h0085
`define JTID_BSR_LONG 126
`define JTID_BSR_SHORT 118
`define JTID_FCTL_W 8
`define JTID_FDAT_W 10
`define JTID_FADR_W 17
`define JTID_FSCL_W 8
`endif

// ---- dv/jtid_tap_monitor.sv ----
`timescale 1ns/1ps
// ****
// Port checker
// ****
module jtid_tap_monitor (
  input wire clk,
  input wire arst_n,
  input wire tck,
  input wire tdo_o,
  input wire tdo_oe,
  input wire [125:0] bsr_update_out,
  input wire bsr_extest,
  input wire [7:0] flash_control_scan_reg,
  input wire [16:0] flash_address_scan_reg,
  input wire [1:0] flash_update_sel,
  input wire flash_update_stb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_stb_pulse: assert property (
    flash_update_stb |=> !flash_update_stb) else $error("strobe too long");
  a_stb_after_rise: assert property (
    flash_update_stb |-> $past(tck, 2)) else $error("strobe without tck rise");
  a_sel_with_stb: assert property (
    $changed(flash_update_sel) |-> flash_update_stb) else $error("select moved alone");
  a_addr_load: assert property (
    $changed(flash_address_scan_reg) |-> flash_update_stb && flash_update_sel == 2'h2)
    else $error("address reg loaded wrongly");
  a_ctl_load: assert property (
    $changed(flash_control_scan_reg) |-> flash_update_stb && flash_update_sel == 2'h0)
    else $error("control reg loaded wrongly");
  a_bsr_extest: assert property (
    $changed(bsr_update_out) |-> bsr_extest) else $error("pin drive changed outside extest");
  a_tdo_on_fall: assert property (
    ($changed(tdo_o) || $changed(tdo_oe)) |-> !$past(tck)) else $error("tdo moved on tck high");
  a_extest_reset: assert property (
    $rose(arst_n) |=> bsr_extest) else $error("extest not selected after reset");
  cover property (flash_update_stb && flash_update_sel == 2'h2);
  cover property ($fell(bsr_extest));
  cover property ($rose(tdo_oe));
endmodule // jtid_tap_monitor

bind jtid_tap jtid_tap_monitor u_mon (.*);

// ---- dv/jtid_tester.sv ----
`timescale 1ns/1ps
// ****
// Scan tester on the four port pins
// ****
module jtid_tester (
  input wire clk,
  input wire tdo_o,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Low 5 clk so tdo has settled before the rise; tck stands high when idle
  task automatic bit_io(input logic m, input logic d, output logic o);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clk);
    o = tdo_o;
    tck <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic tap_reset();
    logic o;
    repeat (5) bit_io(1'b1, 1'b0, o);
    bit_io(1'b0, 1'b0, o);
  endtask
  // Full length always shifted, LSB first, ends in idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
    dout = '0;
    bit_io(1'b1, 1'b0, o);
    if (ir) bit_io(1'b1, 1'b0, o);
    bit_io(1'b0, 1'b0, o);
    bit_io(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], o);
      dout[i] = o;
    end
    bit_io(1'b1, 1'b0, o);
    bit_io(1'b0, 1'b0, o);
    // Update acts on the tck rise seen after the last call; let it land
    repeat (4) @(posedge clk);
  endtask
endmodule // jtid_tester

// ---- dv/jtid_tap_tb.sv ----
`timescale 1ns/1ps
`include "jtid_regs.vh"
// ****
// Bench
// ****
module jtid_tap_tb;
  localparam logic [31:0] ID = 32'h00001001; // Arbitrary identity value
  logic clk, arst_n, clk_en, tck, tms, tdi, tdo_o, tdo_oe, bsr_extest, stb;
  logic [125:0] cap_in, upd_out, upd_exp;
  logic [7:0] fctl, fscl;
  logic [9:0] fdat;
  logic [16:0] fadr;
  logic [1:0] fsel;
  logic [127:0] din, dout;
  logic [31:0] seed = 32'h1aeae73e;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int stb_n = 0;
  logic oe_seen = 1'b0;
  always @(posedge clk) begin
    if (stb === 1'b1) stb_n <= stb_n + 1;
    if (tdo_oe === 1'b1) oe_seen <= 1'b1;
  end
  logic [15:0] codes [9] = '{`JTID_OP_EXTEST, `JTID_OP_SAMPLE, `JTID_OP_IDCODE,
    `JTID_OP_BYPASS, `JTID_OP_FCTL, `JTID_OP_FDAT, `JTID_OP_FADR, `JTID_OP_FSCL, 16'h1234};
  int lens [9] = '{126, 126, 32, 8, 8, 10, 17, 8, 8};
  jtid_tap #(.LONG_VARIANT(1), .ID_VALUE(ID)) uut (.clk(clk), .arst_n(arst_n),
    .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .bsr_capture_in(cap_in), .bsr_update_out(upd_out), .bsr_extest(bsr_extest),
    .flash_control_scan_reg(fctl), .flash_data_scan_reg(fdat),
    .flash_address_scan_reg(fadr), .flash_scale_scan_reg(fscl),
    .flash_update_sel(fsel), .flash_update_stb(stb));
  jtid_tester u_tst (.clk(clk), .tdo_o(tdo_o), .tck(tck), .tms(tms), .tdi(tdi));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Run is about 4.9k clk; ceiling leaves margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    cap_in = '0;
    upd_exp = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("extest_after_reset", 1, bsr_extest);
    u_tst.tap_reset();
    for (int k = 0; k < 9; k++) begin
      din = {rnd(), rnd(), rnd(), rnd()};
      cap_in <= din[125:0];
      u_tst.scan(1'b1, 16, {112'h0, codes[k]}, dout);
      chk("ir_capture", 16'h0001, dout[15:0]);
      chk("extest_flag", codes[k] == `JTID_OP_EXTEST, bsr_extest);
      din = {rnd(), rnd(), rnd(), rnd()};
      u_tst.scan(1'b0, lens[k], din, dout);
      if (k < 2) chk("bsr_capture", cap_in, dout[125:0]);
      if (k == 0) upd_exp = din[125:0];
      chk("bsr_update", upd_exp, upd_out);
      if (k == 2) chk("id_value", ID, dout[31:0]);
      if (k == 3 || k == 8) chk("bypass", {din[6:0], 1'b0}, dout[7:0]);
      if (k > 3 && k < 8) chk("flash_sel", k - 4, fsel);
      if (k == 4) chk("flash_ctl", din[7:0], fctl);
      if (k == 5) chk("flash_dat", din[9:0], fdat);
      if (k == 6) chk("flash_adr", din[16:0], fadr);
      if (k == 7) chk("flash_scl", din[7:0], fscl);
      clk_en <= 1'b0;
      repeat (4) @(posedge clk);
      clk_en <= 1'b1;
    end
    chk("strobe_count", 4, stb_n);
    chk("tdo_enable_seen", 1, oe_seen);
    end_sim();
  end
endmodule // jtid_tap_tb
